//--- inc/ais_cfg.svh
// Purpose: constants of the analog input slot sequencer
// Assumes: 20 MHz core clock, 32768 Hz frame time base
// Notes: register indices; byte address is four times the index
`ifndef AIS_CFG_SVH
`define AIS_CFG_SVH
`define AIS_IDX_CNT_S10 14'h2100
`define AIS_IDX_S8_9 14'h2101
`define AIS_IDX_S6_7 14'h2102
`define AIS_IDX_S4_5 14'h2103
`define AIS_IDX_S2_3 14'h2104
`define AIS_IDX_S0_1 14'h2105
`define AIS_IDX_EQU 14'h2106
`define AIS_IDX_MODE 14'h210C
`define AIS_IDX_CLK 14'h2200
`define AIS_IDX_PRE 14'h2704
`define AIS_IDX_RMT 14'h2709
`define AIS_IDX_STATUS 14'h2110
`define AIS_CFG_RESET 8'h00
`define AIS_CNT_LSB 4
`define AIS_DIFF_LSB 4
`define AIS_DLEN_LSB 1
`define AIS_CONV_SLOW_BIT 5
`define AIS_FAST_SYS_BIT 4
`define AIS_PRE_BIT 5
`define AIS_RMT_LSB 3
`define AIS_EQU_LSB 5
`define AIS_MAX_CODE 4'hA
`define AIS_CORE_HZ 20000000
`define AIS_SLOW_HZ 32768
`define AIS_SLOW_DIV (`AIS_CORE_HZ / `AIS_SLOW_HZ)
`define AIS_TICKS_PER_SLOT 2
`endif

//--- inc/ais_pkg.sv
// Purpose: types of the analog input slot sequencer
// Assumes: nothing
// Notes: state and output carriers
package ais_pkg;
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_SLOT, SEQ_TAIL} ais_seq_t;
    typedef struct packed {
        logic [10:0] pos_sel;
        logic [7:0] neg_sel;
        logic remote_slot;
        logic bad_code;
        logic [3:0] slot_idx;
        logic [3:0] src_code;
        logic conv_start;
        logic frame_start;
        logic gain8;
        logic [3:0] diff_eff;
        logic [2:0] remote_en;
        logic [1:0] dec_len;
        logic conv_clk_slow;
        logic fast_sys_clk;
        logic [2:0] eq_sel;
    } ais_afe_t;
    typedef struct packed {
        logic [10:0][7:0] cfg;
        logic [9:0] div_cnt;
        ais_seq_t seq;
        logic [3:0] slot;
        logic half;
        logic [3:0] frame_len;
        logic [7:0] frame_cnt;
        logic wr_pend;
        logic [3:0] wr_sel;
        logic [31:0] rdata;
        ais_afe_t afe;
    } ais_state_t;
endpackage

//--- logic/ais_sequencer.sv
// Purpose: steps the single converter through a frame of input slots
// Assumes: AHB-Lite single word transfers, one clock, sync reset
// Notes: zero wait state slave, response always OKAY
// Function
// - route one input per slot, in slot order, from 4-bit selects
// - all single-ended: eleven selectable input signals
// - differential pairs: four current pairs plus three voltages
// - slot count is upper nibble of control byte 0x2100
// - frame starts at slot 0, runs slot count slots, rest unused
// - selects two per byte, lower nibble first, 2105 down to 2100
// - codes 0,2,4,6 are current pairs, 8,9,A voltages
// - 2709 bits 3..5 switch pairs 2/3,4/5,6/7 to remote
// - a remote pair ignores its differential enable bit
// - 210C bits 4..7 make current pairs differential
// - 2704 bit 5 sets pair 0/1 gain to 8, else 1
// - 210C bits 2:1 select decimator length, 1 is 288
// - 2200 bit 5 converter clock speed, bit 4 fast system clock
// - 2106 bits 7:5 select the energy equation
// - six slots make a frame of 13 slow clock cycles
//
// The AHB-Lite slave port was chosen for this implementation.
`include "ais_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module ais_sequencer (
    input wire logic core_clk_in, // 20 MHz clock
    input wire logic sys_rst_in, // sync reset, high
    input wire logic hsel_in, // slave select
    input wire logic [31:0] haddr_in, // byte address
    input wire logic [1:0] htrans_in, // transfer type
    input wire logic hwrite_in, // write when high
    input wire logic [2:0] hsize_in, // transfer size
    input wire logic [31:0] hwdata_in, // write data
    input wire logic hready_in, // bus ready
    output logic hreadyout_out, // slave ready
    output logic hresp_out, // response, always OKAY
    output logic [31:0] hrdata_out, // read data
    output ais_pkg::ais_afe_t afe_out // converter front end control
);
    localparam logic [9:0] DIV_LAST = 10'(`AIS_SLOW_DIV - 1);
    localparam logic [3:0] NONE = 4'hF;

    ais_pkg::ais_state_t st_reg;
    ais_pkg::ais_state_t st_next;

    logic tick;
    logic [3:0] addr_sel;
    logic [3:0] cnt_field;
    logic [3:0] code;
    logic [3:0] slot_n;
    logic [2:0] byte_n;
    logic [7:0] sel_byte;
    logic [2:0] rmt;
    logic [3:0] diff_raw;
    logic [3:0] diff_eff;
    logic [7:0] wbyte;
    logic take;

    // map a word index to a config slot; status reads as slot 11
    function automatic logic [3:0] idx_to_sel(input logic [29:0] idx);
        logic [3:0] sel;
        sel = NONE;
        unique case (idx)
            30'(`AIS_IDX_CNT_S10): sel = 4'h0;
            30'(`AIS_IDX_S8_9): sel = 4'h1;
            30'(`AIS_IDX_S6_7): sel = 4'h2;
            30'(`AIS_IDX_S4_5): sel = 4'h3;
            30'(`AIS_IDX_S2_3): sel = 4'h4;
            30'(`AIS_IDX_S0_1): sel = 4'h5;
            30'(`AIS_IDX_EQU): sel = 4'h6;
            30'(`AIS_IDX_MODE): sel = 4'h7;
            30'(`AIS_IDX_CLK): sel = 4'h8;
            30'(`AIS_IDX_PRE): sel = 4'h9;
            30'(`AIS_IDX_RMT): sel = 4'hA;
            30'(`AIS_IDX_STATUS): sel = 4'hB;
            default: sel = NONE;
        endcase
        return sel;
    endfunction

    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign hrdata_out = st_reg.rdata;
    assign afe_out = st_reg.afe;

    assign take = hsel_in & htrans_in[1] & hready_in;
    assign addr_sel = idx_to_sel(haddr_in[31:2]);
    assign wbyte = hwdata_in[7:0];
    assign tick = (st_reg.div_cnt == DIV_LAST);

    always_comb begin
        st_next = st_reg;
        st_next.afe.conv_start = 1'b0;
        st_next.afe.frame_start = 1'b0;

        // bus data phase: writes land one cycle after the address phase
        st_next.wr_pend = take & hwrite_in & (addr_sel < 4'hB);
        st_next.wr_sel = addr_sel;
        if (st_reg.wr_pend) begin
            st_next.cfg[st_reg.wr_sel] = wbyte;
        end
        if (take & ~hwrite_in) begin
            if (addr_sel < 4'hB) begin
                st_next.rdata = {24'h000000, st_reg.cfg[addr_sel]};
            end else if (addr_sel == 4'hB) begin
                st_next.rdata = {16'h0000, st_reg.frame_cnt,
                    2'(st_reg.seq), st_reg.half, 1'b0, st_reg.slot};
            end else begin
                st_next.rdata = 32'h00000000;
            end
        end

        // slow time base, one enable pulse per 32 kHz period
        st_next.div_cnt = tick ? 10'h000 : st_reg.div_cnt + 10'h001;

        // count is read live so writing zero stops at once
        cnt_field = st_next.cfg[0][`AIS_CNT_LSB +: 4];

        if (cnt_field == 4'h0) begin
            st_next.seq = ais_pkg::SEQ_IDLE;
            st_next.slot = 4'h0;
            st_next.half = 1'b0;
        end else if (tick) begin
            unique case (st_reg.seq)
                ais_pkg::SEQ_IDLE,
                ais_pkg::SEQ_TAIL: begin
                    // every frame opens at slot 0
                    st_next.seq = ais_pkg::SEQ_SLOT;
                    st_next.slot = 4'h0;
                    st_next.half = 1'b0;
                    st_next.frame_len = cnt_field;
                    st_next.afe.conv_start = 1'b1;
                    st_next.afe.frame_start = 1'b1;
                    if (st_reg.seq == ais_pkg::SEQ_TAIL) begin
                        st_next.frame_cnt = st_reg.frame_cnt + 8'h01;
                    end
                end
                ais_pkg::SEQ_SLOT: begin
                    // two ticks per slot plus one tail tick
                    if (st_reg.half == 1'b0) begin
                        st_next.half = 1'b1;
                    end else if (st_reg.slot == st_reg.frame_len - 4'h1) begin
                        st_next.seq = ais_pkg::SEQ_TAIL;
                        st_next.half = 1'b0;
                    end else begin
                        st_next.slot = st_reg.slot + 4'h1;
                        st_next.half = 1'b0;
                        st_next.afe.conv_start = 1'b1;
                    end
                end
            endcase
        end

        // slot select: two per byte, low nibble first
        slot_n = st_next.slot;
        byte_n = 3'(4'h5 - {1'b0, slot_n[3:1]});
        sel_byte = st_next.cfg[byte_n];
        code = slot_n[0] ? sel_byte[7:4] : sel_byte[3:0];

        rmt = st_next.cfg[10][`AIS_RMT_LSB +: 3];
        diff_raw = st_next.cfg[7][`AIS_DIFF_LSB +: 4];
        diff_eff = diff_raw & ~{rmt, 1'b0};

        st_next.afe.slot_idx = slot_n;
        st_next.afe.src_code = code;
        st_next.afe.pos_sel = 11'h000;
        st_next.afe.neg_sel = 8'h00;
        st_next.afe.remote_slot = 1'b0;
        st_next.afe.bad_code = 1'b0;
        if (st_next.seq == ais_pkg::SEQ_SLOT) begin
            if (code > `AIS_MAX_CODE) begin
                // illegal code: converter left unconnected
                st_next.afe.bad_code = 1'b1;
            end else if (code[3]) begin
                // voltage inputs are always single ended
                st_next.afe.pos_sel[code] = 1'b1;
            end else if (code[2:1] != 2'b00 && rmt[code[2:1] - 2'h1]) begin
                // remote pair samples bypass the multiplexer
                st_next.afe.remote_slot = 1'b1;
            end else if (diff_eff[code[2:1]]) begin
                // differential pair: even pin plus, odd pin minus
                st_next.afe.pos_sel[{code[2:1], 1'b0}] = 1'b1;
                st_next.afe.neg_sel[{code[2:1], 1'b1}] = 1'b1;
            end else begin
                // single ended: each pin its own source
                st_next.afe.pos_sel[code] = 1'b1;
            end
        end

        st_next.afe.diff_eff = diff_eff;
        st_next.afe.remote_en = rmt;
        st_next.afe.gain8 = st_next.cfg[9][`AIS_PRE_BIT];
        st_next.afe.dec_len = st_next.cfg[7][`AIS_DLEN_LSB +: 2];
        st_next.afe.conv_clk_slow =
            st_next.cfg[8][`AIS_CONV_SLOW_BIT];
        st_next.afe.fast_sys_clk =
            st_next.cfg[8][`AIS_FAST_SYS_BIT];
        st_next.afe.eq_sel = st_next.cfg[6][`AIS_EQU_LSB +: 3];
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule // ais_sequencer
`default_nettype wire

//--- sim/ais_seq_sva.sv
// Purpose: port checks of the slot sequencer
// Assumes: one clock, sync reset high
// Notes: frame length spans thousands of cycles, so the bench judges it
`timescale 1ns/100ps
`default_nettype none
module ais_seq_sva (
    input wire logic core_clk_in, // clock
    input wire logic sys_rst_in, // reset
    input wire ais_pkg::ais_afe_t afe_out // mux controls
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    a_one_input: assert property ($onehot0(afe_out.pos_sel))
        else $error("two pins at once");
    a_frame_slot0: assert property (afe_out.frame_start |->
        afe_out.conv_start && afe_out.slot_idx == 4'h0)
        else $error("frame not at slot 0");
    a_slot_step: assert property (afe_out.conv_start &&
        !afe_out.frame_start |-> afe_out.slot_idx ==
        $past(afe_out.slot_idx) + 4'h1) else $error("slot skipped");
    a_pulse_once: assert property (afe_out.conv_start |=>
        !afe_out.conv_start [*8]) else $error("slot start too long");
    a_remote_mask: assert property (
        (afe_out.diff_eff[3:1] & afe_out.remote_en) == 3'h0)
        else $error("remote pair kept differential");
    a_volt_route: assert property (afe_out.conv_start &&
        afe_out.src_code inside {4'h8, 4'h9, 4'hA} |->
        afe_out.pos_sel == 11'h001 << afe_out.src_code)
        else $error("voltage pin wrong");
    a_diff_pair: assert property (afe_out.conv_start &&
        afe_out.src_code == 4'h0 && afe_out.diff_eff[0] |->
        afe_out.neg_sel == 8'h02) else $error("minus pin wrong");
    a_remote_nopin: assert property (afe_out.remote_slot |->
        afe_out.pos_sel == 11'h000) else $error("remote slot has pin");
    c_frame: cover property (afe_out.frame_start);
    c_remote: cover property (afe_out.remote_slot);
    c_diff: cover property (afe_out.conv_start && afe_out.neg_sel != 8'h00);
endmodule // ais_seq_sva
bind ais_sequencer ais_seq_sva i_sva (.core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in), .afe_out(afe_out));
`default_nettype wire

//--- sim/ais_pin_model.sv
// Purpose: analog pins seen at the converter input
// Assumes: one-hot plus-side select
// Notes: pin k holds 40h+k; an open mux floats, so it drifts every cycle
`timescale 1ns/100ps
`default_nettype none
module ais_pin_model (
    input wire logic core_clk_in, // clock
    input wire ais_pkg::ais_afe_t afe_in, // mux controls
    output logic [7:0] sample_out // converter input level
);
    logic [7:0] drift = 8'h00;
    always @(posedge core_clk_in) drift <= drift + 8'h35;
    always_comb begin
        sample_out = drift;
        for (int k = 0; k < 11; k++) begin
            if (afe_in.pos_sel[k]) sample_out = 8'h40 + 8'(k);
        end
    end
endmodule // ais_pin_model
`default_nettype wire

//--- sim/ais_sequencer_tb_top.sv
// Purpose: self-checking bench of the slot sequencer
// Assumes: zero wait bus slave, 610 core cycles per slow tick
// Notes: first frame after setup is skipped, selects may land inside it
`include "ais_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin \
  n_mismatch++; $display("[FAIL] %s exp %0h got %0h", nm, ex, gt); end end
module ais_sequencer_tb_top;
    logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hrdy, hresp;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
    logic [7:0] smp;
    logic [14:0] cfg;
    ais_pkg::ais_afe_t afe;
    int n_mismatch = 0, cmp_count = 0, cyc = 0;
    assign cfg = {afe.gain8, afe.diff_eff, afe.remote_en, afe.dec_len,
        afe.conv_clk_slow, afe.fast_sys_clk, afe.eq_sel};
    initial forever #25 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    ais_sequencer i_dut (.core_clk_in(clk), .sys_rst_in(rst), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hrdy),
        .hreadyout_out(hrdy), .hresp_out(hresp), .hrdata_out(hrdata),
        .afe_out(afe));
    ais_pin_model i_pins (.core_clk_in(clk), .afe_in(afe), .sample_out(smp));
    task results;
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task wt(input logic cv);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while ((cv ? afe.conv_start : hrdy) !== 1'b1 && n < 2000);
        if (n >= 2000) begin
            n_mismatch++;
            results;
        end
    endtask
    task bus(input logic w, input logic [13:0] ix, input logic [7:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {16'h0, ix, 2'h0};
        wt(1'b0);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wt(1'b0);
        q = hrdata;
    endtask
    task wait_frame;
        for (int i = 0; i < 16; i++) begin
            wt(1'b1);
            if (afe.frame_start === 1'b1) break;
        end
    endtask
    task setup(input logic [7:0] mode, pre, rmt, input logic [3:0] cnt,
               input logic [31:0] sel);
        bus(1'b1, `AIS_IDX_CNT_S10, 8'h00);
        bus(1'b1, `AIS_IDX_MODE, mode);
        bus(1'b1, `AIS_IDX_CLK, 8'h10);
        bus(1'b1, `AIS_IDX_PRE, pre);
        bus(1'b1, `AIS_IDX_RMT, rmt);
        bus(1'b1, `AIS_IDX_EQU, 8'hA0);
        bus(1'b1, `AIS_IDX_CNT_S10, {cnt, 4'h0});
        bus(1'b1, `AIS_IDX_S0_1, sel[7:0]);
        bus(1'b1, `AIS_IDX_S2_3, sel[15:8]);
        bus(1'b1, `AIS_IDX_S4_5, sel[23:16]);
        bus(1'b1, `AIS_IDX_S6_7, sel[31:24]);
    endtask
    task run_frame(input logic [3:0] cnt, input logic [27:0] codes, pins);
        int t0;
        logic [3:0] p;
        wait_frame;
        wait_frame;
        t0 = cyc;
        for (int k = 0; k < cnt; k++) begin
            if (k > 0) wt(1'b1);
            p = pins[4*k +: 4];
            `CHK("slot", 4'(k), afe.slot_idx)
            `CHK("code", codes[4*k +: 4], afe.src_code)
            `CHK("pos", p == 4'hF ? 11'h0 : 11'h1 << p, afe.pos_sel)
            if (p != 4'hF) `CHK("pin", 8'h40 + 8'(p), smp)
        end
        wt(1'b1);
        `CHK("restart", 1'b1, afe.frame_start)
        `CHK("period", (`AIS_TICKS_PER_SLOT * cnt + 1) * `AIS_SLOW_DIV,
            cyc - t0)
    endtask
    task t_regs;
        logic [13:0] ix [11] = '{`AIS_IDX_S8_9, `AIS_IDX_S6_7, `AIS_IDX_S4_5,
            `AIS_IDX_S2_3, `AIS_IDX_S0_1, `AIS_IDX_EQU, `AIS_IDX_MODE,
            `AIS_IDX_CLK, `AIS_IDX_PRE, `AIS_IDX_RMT, `AIS_IDX_CNT_S10};
        for (int i = 0; i < 11; i++) begin
            bus(1'b0, ix[i], 8'h00);
            `CHK("reset", 32'h0, q)
            bus(1'b1, ix[i], 8'hA5);
            bus(1'b0, ix[i], 8'h00);
            `CHK("rdback", 32'hA5, q)
        end
        `CHK("cfg", {1'b1, 4'h2, 3'h4, 2'h2, 2'h2, 3'h5}, cfg)
        bus(1'b1, 14'h2300, 8'hFF);
        bus(1'b0, 14'h2300, 8'h00);
        `CHK("unmapped", 32'h0, q)
        `CHK("okay", 1'b0, hresp)
        bus(1'b1, `AIS_IDX_CNT_S10, 8'h00);
    endtask
    task t_shunt;
        setup(8'h12, 8'h20, 8'h38, 4'h6, 32'h00A98110);
        run_frame(4'h6, 28'h0A98110, 28'h0A98000);
        `CHK("cfg", {1'b1, 4'h1, 3'h7, 2'h1, 2'h1, 3'h5}, cfg)
    endtask
    task t_ct;
        setup(8'hF2, 8'h00, 8'h00, 4'h7, 32'h00A69482);
        run_frame(4'h7, 28'h0A69482, 28'h0A69482);
        `CHK("cfg", {1'b0, 4'hF, 3'h0, 2'h1, 2'h1, 3'h5}, cfg)
    endtask
    task t_single;
        int n;
        setup(8'h00, 8'h00, 8'h08, 4'h4, 32'h0000A723);
        // codes 3 and 2 both belong to the remote pair 2/3: no pin at all
        run_frame(4'h4, 28'h000A723, 28'h000A7FF);
        bus(1'b1, `AIS_IDX_CNT_S10, 8'h00);
        repeat (2) @(posedge clk);
        `CHK("stop", 11'h0, afe.pos_sel)
        // a zero count must keep the sequencer quiet past a whole slot
        n = 0;
        repeat (1500) begin
            @(posedge clk);
            if (afe.conv_start === 1'b1) n++;
        end
        `CHK("idle", 0, n)
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs;
        t_shunt;
        t_ct;
        t_single;
        results;
    end
endmodule // ais_sequencer_tb_top
`default_nettype wire
